// ---- awd_top.sv ----
// Function
// - Format clear selects base and size
// - Size counts compared top base bits
// - Start address zeroes uncompared base bits
// - Size n compares n bits from top
// - Size zero matches every address
// - Direction bit picks inbound or outbound
// - Format set selects high and low bounds
// - High at least low maps inbound
// - Swapped bounds decode as outbound window
// - Both bounds zero disables window
// - Separate windows for four address spaces
// - All windows disabled after reset
//
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
module awd_top (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic [awd_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [awd_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic LOOKUP_VALID,
  input wire logic [1:0] LOOKUP_SPACE,
  input wire logic [7:0] LOOKUP_ADDR,
  output logic RESULT_VALID,
  output logic RESULT_HIT,
  output logic RESULT_INBOUND,
  output logic [7:0] RESULT_START
);
  awd_pkg::awd_state_s s;
  awd_pkg::awd_state_s next_s;
  logic [awd_pkg::NUM_WIN-1:0] m_hit;
  logic [awd_pkg::NUM_WIN-1:0] m_inbound;
  logic [7:0] m_start [awd_pkg::NUM_WIN];
  awd_pkg::awd_win_s sel_win;

  // One matcher per address space so every space decodes in parallel.
  for (genvar g = 0; g < awd_pkg::NUM_WIN; g++) begin : g_win
    awd_match u_match (
      .window_format_select(s.window_format_select),
      .win(s.win[g]),
      .addr(LOOKUP_ADDR),
      .hit(m_hit[g]),
      .inbound(m_inbound[g]),
      .start(m_start[g])
    );
  end

  assign sel_win = s.win[LOOKUP_SPACE];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] win_word(input awd_pkg::awd_win_s w);
    logic [31:0] r;
    r = awd_pkg::WORD_ZERO;
    r[awd_pkg::WIN_HB_LSB +: 8] = w.high_base;
    r[awd_pkg::WIN_LS_LSB +: 8] = w.low_size;
    r[awd_pkg::WIN_DIR_BIT] = w.direction;
    r[awd_pkg::WIN_EN_BIT] = w.enable;
    return r;
  endfunction

  always_comb begin
    logic [5:0] wa;
    logic [5:0] ra;
    logic [31:0] nw;
    logic [1:0] wi;
    next_s = s;
    wa = s.aw_addr[7:2];
    ra = S_AXI_ARADDR[7:2];
    nw = awd_pkg::WORD_ZERO;
    wi = wa[1:0];
    // Address and data are taken independently, in either order.
    if (s.awready && S_AXI_AWVALID) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = S_AXI_AWADDR;
    end
    if (s.wready && S_AXI_WVALID) begin
      next_s.w_got = 1'b1;
      next_s.w_data = S_AXI_WDATA;
      next_s.w_strb = S_AXI_WSTRB;
    end
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = awd_pkg::RESP_OKAY;
      if (wa == awd_pkg::WORD_CTRL) begin
        if (s.w_strb[0]) begin
          next_s.window_format_select = s.w_data[awd_pkg::CTRL_FMT_BIT];
        end
      end else if (wa == awd_pkg::WORD_STATUS) begin
        // Status is read-only; a write is accepted and has no effect.
        next_s.bresp = awd_pkg::RESP_OKAY;
      end else if (wa >= awd_pkg::WORD_WIN0 && wa < awd_pkg::WORD_WIN0 + 6'h04) begin
        nw = merge(win_word(s.win[wi]), s.w_data, s.w_strb);
        next_s.win[wi].high_base = nw[awd_pkg::WIN_HB_LSB +: 8];
        next_s.win[wi].low_size = nw[awd_pkg::WIN_LS_LSB +: 8];
        next_s.win[wi].direction = nw[awd_pkg::WIN_DIR_BIT];
        next_s.win[wi].enable = nw[awd_pkg::WIN_EN_BIT];
      end else begin
        next_s.bresp = awd_pkg::RESP_SLVERR;
      end
    end
    if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid = 1'b0;
    end
    if (s.arready && S_AXI_ARVALID) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = awd_pkg::RESP_OKAY;
      next_s.rdata = awd_pkg::WORD_ZERO;
      if (ra == awd_pkg::WORD_CTRL) begin
        next_s.rdata[awd_pkg::CTRL_FMT_BIT] = s.window_format_select;
      end else if (ra == awd_pkg::WORD_STATUS) begin
        next_s.rdata[awd_pkg::ST_HIT_BIT] = s.res_hit;
        next_s.rdata[awd_pkg::ST_INB_BIT] = s.res_inbound;
        next_s.rdata[awd_pkg::ST_SPACE_LSB +: 2] = s.res_space;
        next_s.rdata[awd_pkg::ST_FMT_BIT] = s.window_format_select;
        next_s.rdata[awd_pkg::ST_VALID_BIT] = s.res_valid;
        next_s.rdata[awd_pkg::ST_START_LSB +: 8] = s.res_start;
      end else if (ra >= awd_pkg::WORD_WIN0 && ra < awd_pkg::WORD_WIN0 + 6'h04) begin
        next_s.rdata = win_word(s.win[ra[1:0]]);
      end else begin
        next_s.rresp = awd_pkg::RESP_SLVERR;
      end
    end
    // Readies drop while a transfer is pending, which limits each side to one in flight.
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;
    // A lookup result stands one cycle; the status copy keeps the last one.
    next_s.res_valid = LOOKUP_VALID;
    if (LOOKUP_VALID) begin
      next_s.res_hit = m_hit[LOOKUP_SPACE];
      next_s.res_inbound = m_inbound[LOOKUP_SPACE];
      next_s.res_space = LOOKUP_SPACE;
      next_s.res_start = m_start[LOOKUP_SPACE];
    end
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      s <= awd_pkg::ST_RESET;
    end else if (CE) begin
      s <= next_s;
    end
  end

  assign S_AXI_AWREADY = s.awready;
  assign S_AXI_WREADY = s.wready;
  assign S_AXI_BVALID = s.bvalid;
  assign S_AXI_BRESP = s.bresp;
  assign S_AXI_ARREADY = s.arready;
  assign S_AXI_RVALID = s.rvalid;
  assign S_AXI_RRESP = s.rresp;
  assign S_AXI_RDATA = s.rdata;
  assign RESULT_VALID = s.res_valid;
  assign RESULT_HIT = s.res_hit;
  assign RESULT_INBOUND = s.res_inbound;
  assign RESULT_START = s.res_start;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_look;
    CE && LOOKUP_VALID;
  endsequence

  sequence s_look_bs;
    s_look and (!s.window_format_select && sel_win.enable);
  endsequence

  sequence s_look_hl;
    s_look and (s.window_format_select && sel_win.enable);
  endsequence

  property p_bs_exact;
    s_look_bs and (LOOKUP_ADDR == sel_win.high_base) |=> RESULT_HIT;
  endproperty
  a_bs_exact: assert property (p_bs_exact) else $error("base address missed");

  property p_bs_top_bit;
    s_look_bs and (sel_win.low_size[2:0] != 3'h0)
      and (LOOKUP_ADDR[7] != sel_win.high_base[7]) |=> !RESULT_HIT;
  endproperty
  a_bs_top_bit: assert property (p_bs_top_bit) else $error("top base bit ignored");

  property p_bs_start;
    s_look_bs |=> (RESULT_START == ($past(sel_win.high_base)
      & ~(awd_pkg::BYTE_ONES >> $past(sel_win.low_size[2:0]))));
  endproperty
  a_bs_start: assert property (p_bs_start) else $error("window start wrong");

  property p_bs_compare;
    s_look_bs and (sel_win.low_size[2:0] != 3'h0) |=> RESULT_HIT ==
      (($past(LOOKUP_ADDR) >> (4'd8 - $past(sel_win.low_size[2:0])))
      == ($past(sel_win.high_base) >> (4'd8 - $past(sel_win.low_size[2:0]))));
  endproperty
  a_bs_compare: assert property (p_bs_compare) else $error("size compare wrong");

  property p_bs_size0;
    s_look_bs and (sel_win.low_size[2:0] == 3'h0) |=> RESULT_HIT && RESULT_START == 8'h00;
  endproperty
  a_bs_size0: assert property (p_bs_size0) else $error("size zero not full range");

  property p_bs_dir;
    s_look_bs |=> RESULT_INBOUND == $past(sel_win.direction);
  endproperty
  a_bs_dir: assert property (p_bs_dir) else $error("direction bit ignored");

  property p_hl_single;
    s_look_hl and (sel_win.high_base == sel_win.low_size) and (sel_win.high_base != 8'h00)
      and (LOOKUP_ADDR == sel_win.high_base) |=> RESULT_HIT && RESULT_INBOUND;
  endproperty
  a_hl_single: assert property (p_hl_single) else $error("high/low format ignored");

  property p_hl_in;
    s_look_hl and (sel_win.high_base > sel_win.low_size)
      and (LOOKUP_ADDR >= sel_win.low_size) and (LOOKUP_ADDR <= sel_win.high_base)
      |=> RESULT_HIT && RESULT_INBOUND;
  endproperty
  a_hl_in: assert property (p_hl_in) else $error("inbound range missed");

  property p_hl_out;
    s_look_hl and (sel_win.high_base < sel_win.low_size)
      and (LOOKUP_ADDR >= sel_win.high_base) and (LOOKUP_ADDR <= sel_win.low_size)
      |=> RESULT_HIT && !RESULT_INBOUND;
  endproperty
  a_hl_out: assert property (p_hl_out) else $error("outbound range missed");

  property p_hl_zero;
    s_look and s.window_format_select and (sel_win.high_base == 8'h00)
      and (sel_win.low_size == 8'h00) |=> !RESULT_HIT;
  endproperty
  a_hl_zero: assert property (p_hl_zero) else $error("zero window matched");

  property p_space;
    s_look |=> RESULT_VALID && RESULT_HIT == $past(m_hit[LOOKUP_SPACE])
      && $past(LOOKUP_SPACE) == s.res_space;
  endproperty
  a_space: assert property (p_space) else $error("wrong space window");

  property p_off;
    s_look and !sel_win.enable |=> !RESULT_HIT;
  endproperty
  a_off: assert property (p_off) else $error("disabled window matched");

  property p_hl_bounds;
    s_look_hl ##1 RESULT_HIT |-> ($past(LOOKUP_ADDR) >= $past(sel_win.high_base)
      || $past(LOOKUP_ADDR) >= $past(sel_win.low_size))
      && ($past(LOOKUP_ADDR) <= $past(sel_win.high_base)
      || $past(LOOKUP_ADDR) <= $past(sel_win.low_size));
  endproperty
  a_hl_bounds: assert property (p_hl_bounds) else $error("hit outside bounds");

  // Within a base/size hit only the uncompared low bits may differ from the start.
  property p_bs_masked;
    s_look_bs ##1 RESULT_HIT |-> RESULT_START == ($past(LOOKUP_ADDR)
      & ~(awd_pkg::BYTE_ONES >> $past(sel_win.low_size[2:0])));
  endproperty
  a_bs_masked: assert property (p_bs_masked) else $error("hit outside block");

  property p_bs_ignored;
    s_look_bs and (((LOOKUP_ADDR ^ sel_win.high_base)
      & ~(awd_pkg::BYTE_ONES >> sel_win.low_size[2:0])) == 8'h00) |=> RESULT_HIT;
  endproperty
  a_bs_ignored: assert property (p_bs_ignored) else $error("ignored bit compared");

  property p_hl_start_in;
    s_look_hl and (sel_win.high_base >= sel_win.low_size) and (sel_win.high_base != 8'h00)
      |=> RESULT_INBOUND && RESULT_START == $past(sel_win.low_size);
  endproperty
  a_hl_start_in: assert property (p_hl_start_in) else $error("inbound start wrong");

  property p_hl_start_out;
    s_look_hl and (sel_win.high_base < sel_win.low_size)
      |=> !RESULT_INBOUND && RESULT_START == $past(sel_win.high_base);
  endproperty
  a_hl_start_out: assert property (p_hl_start_out) else $error("outbound start wrong");

  property p_hl_below;
    s_look_hl and (LOOKUP_ADDR < sel_win.high_base) and (LOOKUP_ADDR < sel_win.low_size)
      |=> !RESULT_HIT;
  endproperty
  a_hl_below: assert property (p_hl_below) else $error("hit below bounds");

  property p_hl_above;
    s_look_hl and (LOOKUP_ADDR > sel_win.high_base) and (LOOKUP_ADDR > sel_win.low_size)
      |=> !RESULT_HIT;
  endproperty
  a_hl_above: assert property (p_hl_above) else $error("hit above bounds");

  // A result is a one-cycle pulse; its fields then hold so the status copy stays meaningful.
  property p_result_pulse;
    CE && !LOOKUP_VALID |=> !RESULT_VALID;
  endproperty
  a_result_pulse: assert property (p_result_pulse) else $error("result stuck");

  property p_result_hold;
    CE && !LOOKUP_VALID |=> $stable(RESULT_HIT) && $stable(RESULT_INBOUND)
      && $stable(RESULT_START);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result not held");

  // A write retires once both halves are in and no response is still waiting.
  sequence s_retire_ctrl;
    CE && s.aw_got && s.w_got && !s.bvalid && s.w_strb[0]
      && (s.aw_addr[7:2] == awd_pkg::WORD_CTRL);
  endsequence

  property p_ctrl_write;
    s_retire_ctrl |=> s.window_format_select == $past(s.w_data[awd_pkg::CTRL_FMT_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("format not written");

  property p_reset_off;
    $fell(RESET) |-> !s.win[0].enable && !s.win[1].enable && !s.win[2].enable
      && !s.win[3].enable && !s.window_format_select;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("window open after reset");
endmodule // awd_top

// ---- awd_match.sv ----
`timescale 1ns/1ns
package awd_pkg;
  localparam int ADDR_W = 8;
  localparam int NUM_WIN = 4;
  localparam logic [5:0] WORD_CTRL = 6'h00;
  localparam logic [5:0] WORD_STATUS = 6'h01;
  localparam logic [5:0] WORD_WIN0 = 6'h04;
  localparam logic [1:0] SPACE_A32 = 2'h0;
  localparam logic [1:0] SPACE_A24 = 2'h1;
  localparam logic [1:0] SPACE_A16 = 2'h2;
  localparam logic [1:0] SPACE_LOGICAL = 2'h3;
  localparam int CTRL_FMT_BIT = 0;
  localparam int WIN_HB_LSB = 0;
  localparam int WIN_LS_LSB = 8;
  localparam int WIN_DIR_BIT = 16;
  localparam int WIN_EN_BIT = 17;
  localparam int ST_HIT_BIT = 0;
  localparam int ST_INB_BIT = 1;
  localparam int ST_SPACE_LSB = 2;
  localparam int ST_FMT_BIT = 4;
  localparam int ST_VALID_BIT = 5;
  localparam int ST_START_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic enable;
    logic direction;
    logic [7:0] low_size;
    logic [7:0] high_base;
  } awd_win_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_got;
    logic [ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic window_format_select;
    awd_win_s [NUM_WIN-1:0] win;
    logic res_valid;
    logic res_hit;
    logic res_inbound;
    logic [1:0] res_space;
    logic [7:0] res_start;
  } awd_state_s;

  localparam awd_state_s ST_RESET = '0;
endpackage

module awd_match (
  input wire logic window_format_select,
  input wire awd_pkg::awd_win_s win,
  input wire logic [7:0] addr,
  output logic hit,
  output logic inbound,
  output logic [7:0] start
);
  logic [7:0] mask;
  logic [7:0] hi;
  logic [7:0] lo;

  always_comb begin
    mask = ~(awd_pkg::BYTE_ONES >> win.low_size[2:0]);
    hi = win.high_base;
    lo = win.low_size;
    hit = 1'b0;
    inbound = 1'b0;
    start = awd_pkg::BYTE_ZERO;
    if (!window_format_select) begin
      hit = win.enable && (((addr ^ win.high_base) & mask) == awd_pkg::BYTE_ZERO);
      inbound = win.direction;
      start = win.high_base & mask;
    end else begin
      // A window with both bounds zero stays closed even when enabled.
      if (win.enable && !(hi == awd_pkg::BYTE_ZERO && lo == awd_pkg::BYTE_ZERO)) begin
        if (hi >= lo) begin
          hit = (addr >= lo) && (addr <= hi);
          inbound = 1'b1;
          start = lo;
        end else begin
          hit = (addr >= hi) && (addr <= lo);
          inbound = 1'b0;
          start = hi;
        end
      end
    end
  end
endmodule // awd_match

// ---- awd_lookup_src.sv ----
`timescale 1ns/1ns
// Lookup requester on the cable-bus side; it registers each request from the bench.
module awd_lookup_src (
  input wire logic clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [1:0] go_space,
  input wire logic [7:0] go_addr,
  output logic valid,
  output logic [1:0] space,
  output logic [7:0] addr
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      valid <= 1'b0;
      space <= 2'h0;
      addr <= 8'h00;
    end else begin
      valid <= go;
      // Idle lines toggle so that a design reading them outside a request shows up.
      space <= go ? go_space : ~space;
      addr <= go ? go_addr : ~addr;
    end
  end
endmodule // awd_lookup_src

// ---- tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  typedef struct packed {logic hit; logic inb; logic [7:0] start;} awd_exp_s;
  logic clk = 1'b0, reset = 1'b1, go = 1'b0, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, go_addr = 8'h00, lk_addr;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic [1:0] go_space = 2'h0, lk_space, bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, lk_valid;
  logic res_valid, res_hit, res_inb;
  logic [7:0] res_start;
  logic [7:0] sh_hb [4] = '{default: 8'h00};
  logic [7:0] sh_ls [4] = '{default: 8'h00};
  logic sh_dir [4] = '{default: 1'b0};
  logic sh_en [4] = '{default: 1'b0};
  logic sh_fmt = 1'b0;
  logic [7:0] hl_a [8] = '{8'h00, 8'h0F, 8'h10, 8'h13, 8'h17, 8'h18, 8'h80, 8'hFF};
  awd_exp_s q[$];
  awd_exp_s mon_e;
  int n_mismatch = 0, num_checks = 0, seed = 76;

  always #10 clk = ~clk;

  awd_top DUT (.CLK(clk), .RESET(reset), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .LOOKUP_VALID(lk_valid), .LOOKUP_SPACE(lk_space), .LOOKUP_ADDR(lk_addr),
    .RESULT_VALID(res_valid), .RESULT_HIT(res_hit), .RESULT_INBOUND(res_inb),
    .RESULT_START(res_start));

  awd_lookup_src u_src (.clk(clk), .reset(reset), .go(go), .go_space(go_space),
    .go_addr(go_addr), .valid(lk_valid), .space(lk_space), .addr(lk_addr));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task results;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic awd_exp_s model(input int s, input logic [7:0] a);
    awd_exp_s e;
    logic [7:0] m, lo, hi;
    m = ~(8'hFF >> sh_ls[s][2:0]);
    if (!sh_fmt) begin
      e.hit = sh_en[s] && (((a ^ sh_hb[s]) & m) == 8'h00);
      e.inb = sh_dir[s];
      e.start = sh_hb[s] & m;
    end else begin
      e.inb = sh_hb[s] >= sh_ls[s];
      lo = e.inb ? sh_ls[s] : sh_hb[s];
      hi = e.inb ? sh_hb[s] : sh_ls[s];
      e.hit = sh_en[s] && hi != 8'h00 && a >= lo && a <= hi;
      e.start = lo;
    end
    return e;
  endfunction

  // One bus transfer; the response ready of its own channel (bready or rready) is raised with the request.
  task axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic [1:0] p);
    @(posedge clk);
    if (wr) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end else begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(wr ? bvalid : rvalid));
    r = rdata;
    p = wr ? bresp : rresp;
    bready <= 1'b0;
    rready <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [31:0] r;
    logic [1:0] p;
    axi(1'b1, a, d, r, p);
    chk(32'(p), 32'(er));
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] r;
    logic [1:0] p;
    axi(1'b0, a, 32'h0000_0000, r, p);
    chk(r, e);
    chk(32'(p), 32'(er));
  endtask

  task setw(input int s, input logic [7:0] hb, input logic [7:0] ls, input logic dir);
    go <= 1'b0;
    sh_hb[s] = hb;
    sh_ls[s] = ls;
    sh_dir[s] = dir;
    sh_en[s] = 1'b1;
    wr(8'h10 + 8'(4 * s), {14'h0000, 1'b1, dir, ls, hb}, awd_pkg::RESP_OKAY);
  endtask

  task look(input int s, input logic [7:0] a);
    q.push_back(model(s, a));
    go <= 1'b1;
    go_space <= 2'(s);
    go_addr <= a;
    @(posedge clk);
  endtask

  task idle(input string name);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    $display("test %s done", name);
  endtask

  // Results are paired with the oldest noted expectation.
  always @(posedge clk) begin
    if (!reset && res_valid) begin
      if (q.size() == 0) chk(32'h0000_0000, 32'h0000_0001);
      else begin
        mon_e = q.pop_front();
        chk(32'(res_hit), 32'(mon_e.hit));
        if (mon_e.hit) chk(32'(res_inb), 32'(mon_e.inb));
        if (mon_e.hit) chk(32'(res_start), 32'(mon_e.start));
      end
    end
  end

  initial begin
    #1000000;
    n_mismatch++;
    results();
  end

  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (int s = 0; s < 4; s++) look(s, 8'($random(seed)));
    idle("after_reset");
    rd(8'h00, 32'h0000_0000, awd_pkg::RESP_OKAY);
    for (int s = 0; s < 4; s++) rd(8'h10 + 8'(4 * s), 32'h0000_0000, awd_pkg::RESP_OKAY);
    for (int n = 0; n < 8; n++) begin
      setw(0, 8'h55, 8'(n), n[0]);
      for (int k = 0; k < 8; k++) look(0, 8'h55 ^ (8'h01 << k));
      look(0, 8'h55);
      look(0, 8'($random(seed)));
      idle("base_size_step");
    end
    rd(8'h10, 32'h0003_0755, awd_pkg::RESP_OKAY);
    for (int s = 0; s < 4; s++) setw(s, 8'(s * 64) | 8'h15, 8'h02, s[0]);
    for (int s = 0; s < 4; s++) begin
      for (int t = 0; t < 4; t++) look(s, 8'(t * 64) | (8'($random(seed)) & 8'h3F));
    end
    idle("separate_spaces");
    // Lookups offered while the enable is low must leave no result and no changed field.
    ce <= 1'b0;
    go <= 1'b1;
    go_addr <= 8'h15;
    repeat (2) @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(res_hit), 32'h0000_0001);
    chk(32'(res_start), 32'h0000_00C0);
    ce <= 1'b1;
    idle("clock_enable");
    wr(8'h00, 32'h0000_0001, awd_pkg::RESP_OKAY);
    sh_fmt = 1'b1;
    setw(0, 8'h17, 8'h10, 1'b0);
    setw(1, 8'h10, 8'h17, 1'b1);
    setw(2, 8'h00, 8'h00, 1'b1);
    setw(3, 8'h80, 8'h80, 1'b0);
    for (int s = 0; s < 4; s++) begin
      for (int i = 0; i < 8; i++) look(s, hl_a[i]);
    end
    idle("high_low");
    // Status keeps the last lookup: a miss at 0xFF in the one-address inbound window.
    rd(8'h04, 32'h0000_801E, awd_pkg::RESP_OKAY);
    wr(8'h04, 32'hFFFF_FFFF, awd_pkg::RESP_OKAY);
    rd(8'h04, 32'h0000_801E, awd_pkg::RESP_OKAY);
    rd(8'h00, 32'h0000_0001, awd_pkg::RESP_OKAY);
    rd(8'h40, 32'h0000_0000, awd_pkg::RESP_SLVERR);
    wr(8'h40, 32'h0000_1234, awd_pkg::RESP_SLVERR);
    idle("registers");
    results();
  end
endmodule // tb_top
